// >>> src/codec_word_ctrl.sv
// Primary serial word exchange with control-bit decode and frame phase steering.
// Notes on behaviour
// - Each primary frame takes 14 data bits plus 2 control bits, sends 16 bits.
// - Undecoded control and terminal combinations only exchange data.
// - Control 00, terminals 01: next sample later by phase step.
// - Control 00, terminals 10: next sample earlier by phase step.
// - Terminals 00, control 01: next sample later by phase step.
// - Terminals 00, control 10: next sample earlier by phase step.
// - Control 00, terminals 11: request a secondary frame.
// - Terminals 00, control 11: request a secondary frame.
// - Secondary frame starts half a sample period after the primary.
// - Output bits change on shift clock rise; input captured on fall.
// - Sample period is frame spacing; an adjustment alters one period only.
`timescale 1ns/10ps
`default_nettype none
module codec_word_ctrl
  import codec_word_pkg::*;
#(
  parameter int SAMPLE_CLKS = SAMPLE_CLKS_DFLT,
  parameter int DEPTH       = FIFO_DEPTH
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic                     sclk,
  input  wire logic                     din,
  input  wire logic                     func_term_hi,
  input  wire logic                     func_term_lo,
  output logic                          frame_sync_n,
  output logic                          dout,
  output logic                          dout_oe,
  input  wire logic signed [STEP_W-1:0] phase_step,
  input  wire logic        [WORD_W-1:0] adc_word,
  output logic                          dac_valid,
  input  wire logic                     dac_ready,
  output logic             [DAC_W-1:0]  dac_word,
  output logic                          dac_overrun,
  output logic             [WORD_W-1:0] sec_word,
  output logic                          sec_valid,
  output logic             [1:0]        ctl_bits
);
  localparam logic [CNT_W-1:0] NOM_LEN  = CNT_W'(SAMPLE_CLKS);
  localparam logic [CNT_W-1:0] HALF_LEN = CNT_W'(SAMPLE_CLKS / 2);

  // Three-stage synchronisers; the first stage feeds only the second.
  logic [SYNC_N-1:0] s1_q;
  logic [SYNC_N-1:0] s2_q;
  logic [SYNC_N-1:0] s3_q;
  logic [SYNC_N-1:0] filt_q;
  wire logic [SYNC_N-1:0] pins_raw = {func_term_hi, func_term_lo, din, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys)
      begin
        if (rst)
        begin
          s1_q[gi]   <= 1'b0;
          s2_q[gi]   <= 1'b0;
          s3_q[gi]   <= 1'b0;
          filt_q[gi] <= 1'b0;
        end
        else
        begin
          s1_q[gi]   <= pins_raw[gi];
          s2_q[gi]   <= s1_q[gi];
          s3_q[gi]   <= s2_q[gi];
          filt_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
        end
      end
    end
  endgenerate

  wire logic agree     = s2_q[PIN_SCLK] == s3_q[PIN_SCLK];
  wire logic sclk_rise = agree && s3_q[PIN_SCLK] && !filt_q[PIN_SCLK];
  wire logic sclk_fall = agree && !s3_q[PIN_SCLK] && filt_q[PIN_SCLK];
  wire logic din_s     = s3_q[PIN_DIN];
  wire logic [1:0] term_code = {filt_q[PIN_FHI], filt_q[PIN_FLO]};

  // Sample period counter.
  logic [CNT_W-1:0] smp_cnt_q;
  logic [CNT_W-1:0] len_q;
  logic             prim_arm_q;
  logic             sec_arm_q;
  logic             sec_req_q;
  wire logic        wrap     = smp_cnt_q >= CNT_W'(len_q - 1'b1);
  wire logic        at_half  = smp_cnt_q == HALF_LEN;

  // Frame engine state.
  frame_st_t         st_q;
  frame_st_t         st_d;
  logic              is_sec_q;
  logic [BIT_W-1:0]  bit_q;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] rx_q;
  wire logic [WORD_W-1:0] rx_word = {rx_q[WORD_W-2:0], din_s};
  wire logic word_end  = (st_q == ST_SHIFT) && sclk_fall && (bit_q == LAST_BIT);
  wire logic prim_done = word_end && !is_sec_q;
  wire logic sec_done  = word_end && is_sec_q;
  wire logic start_prim = (st_q == ST_IDLE) && sclk_rise && prim_arm_q;
  wire logic start_sec  = (st_q == ST_IDLE) && sclk_rise && !prim_arm_q && sec_arm_q;

  // Decode: terminals steer when the control bits are idle and vice versa.
  wire logic [1:0] ctl_code = rx_word[1:0];
  wire logic [1:0] code_sel = (ctl_code == CODE_NONE) ? term_code :
                              (term_code == CODE_NONE) ? ctl_code : CODE_NONE;
  wire action_t act = (code_sel == CODE_LATER)   ? ACT_LATER :
                      (code_sel == CODE_EARLIER) ? ACT_EARLIER :
                      (code_sel == CODE_SEC)     ? ACT_SEC :
                      ACT_NONE;
  wire logic adj_go  = prim_done && (act == ACT_LATER || act == ACT_EARLIER);
  wire logic sec_go  = prim_done && (act == ACT_SEC);

  // Adjusted period, held no shorter than the secondary word needs.
  wire logic signed [CNT_W:0] nom_s  = {1'b0, NOM_LEN};
  wire logic signed [CNT_W:0] step_s = {{(CNT_W+1-STEP_W){phase_step[STEP_W-1]}}, phase_step};
  wire logic signed [CNT_W:0] adj_s  = (act == ACT_LATER) ? nom_s + step_s : nom_s - step_s;
  wire logic signed [CNT_W:0] min_s  = {1'b0, LEN_MIN};
  wire logic [CNT_W-1:0] adj_len = (adj_s < min_s) ? LEN_MIN : adj_s[CNT_W-1:0];
  // Plain sign extension of the step, kept apart from the clamp arithmetic for the checks.
  wire logic [CNT_W-1:0] step_ext = CNT_W'(phase_step);

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      smp_cnt_q <= '0;
      len_q     <= NOM_LEN;
    end
    else
    begin
      smp_cnt_q <= wrap ? '0 : CNT_W'(smp_cnt_q + 1'b1);
      len_q     <= adj_go ? adj_len : (wrap ? NOM_LEN : len_q);
    end
  end

  // Arming flags; a new set wins over a clear in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prim_arm_q <= 1'b0;
      sec_req_q  <= 1'b0;
      sec_arm_q  <= 1'b0;
    end
    else
    begin
      prim_arm_q <= wrap || (prim_arm_q && !start_prim);
      sec_req_q  <= sec_go || (sec_req_q && !at_half);
      sec_arm_q  <= (sec_req_q && at_half) || (sec_arm_q && !start_sec);
    end
  end

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:  st_d = (start_prim || start_sec) ? ST_SHIFT : ST_IDLE;
      ST_SHIFT: st_d = word_end ? ST_TAIL : ST_SHIFT;
      ST_TAIL:  st_d = sclk_rise ? ST_IDLE : ST_TAIL;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_q     <= ST_IDLE;
      is_sec_q <= 1'b0;
      bit_q    <= '0;
      tx_q     <= '0;
      rx_q     <= '0;
    end
    else
    begin
      st_q     <= st_d;
      is_sec_q <= start_sec ? 1'b1 : (start_prim ? 1'b0 : is_sec_q);
      bit_q    <= (start_prim || start_sec) ? '0 :
                  (sclk_fall ? BIT_W'(bit_q + 1'b1) : bit_q);
      tx_q     <= start_prim ? {adc_word[WORD_W-2:0], 1'b0} :
                  (sclk_rise ? {tx_q[WORD_W-2:0], 1'b0} : tx_q);
      rx_q     <= (st_q == ST_SHIFT && sclk_fall) ? rx_word : rx_q;
    end
  end

  // Pin drivers: the data line changes only on a shift clock rise.
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      frame_sync_n <= 1'b1;
      dout         <= 1'b0;
      dout_oe      <= 1'b0;
    end
    else if (start_prim || start_sec)
    begin
      frame_sync_n <= 1'b0;
      dout         <= start_prim && adc_word[WORD_W-1];
      dout_oe      <= start_prim;
    end
    else if (sclk_rise)
    begin
      frame_sync_n <= 1'b1;
      dout         <= (st_q == ST_SHIFT) && !is_sec_q && tx_q[WORD_W-1];
      dout_oe      <= (st_q == ST_SHIFT) && !is_sec_q;
    end
  end

  // The serial link cannot stall, so a full FIFO drops the word and flags it.
  logic fifo_in_ready;
  word_fifo #(
    .W     (DAC_W),
    .DEPTH (DEPTH)
  ) u_dac_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (prim_done),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word[WORD_W-1:2]),
    .out_valid (dac_valid),
    .out_ready (dac_ready),
    .out_data  (dac_word)
  );

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dac_overrun <= 1'b0;
      sec_word    <= '0;
      sec_valid   <= 1'b0;
      ctl_bits    <= '0;
    end
    else
    begin
      dac_overrun <= prim_done && !fifo_in_ready;
      sec_word    <= sec_done ? rx_word : sec_word;
      sec_valid   <= sec_done;
      ctl_bits    <= prim_done ? ctl_code : ctl_bits;
    end
  end

  sequence seq_prim_end;
    prim_done && fifo_in_ready;
  endsequence

  sequence seq_half_arm;
    sec_req_q && at_half;
  endsequence

  AST_FS_ON_RISE: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(frame_sync_n) |-> $past(sclk_rise))
    else $error("Frame sync fell without a shift clock rise.");

  AST_DOUT_ON_RISE: assert property (@(posedge clk_sys) disable iff (rst)
    (dout_oe && $changed(dout)) |-> $past(sclk_rise))
    else $error("Output data changed away from a shift clock rise.");

  AST_WORD_SPLIT: assert property (@(posedge clk_sys) disable iff (rst)
    seq_prim_end |=> (ctl_bits == $past(rx_word[1:0])) && dac_valid)
    else $error("Primary word not split into data and control bits.");

  AST_LATER: assert property (@(posedge clk_sys) disable iff (rst)
    (adj_go && act == ACT_LATER && adj_s >= min_s) |=>
      CNT_W'(len_q - $past(step_ext)) == NOM_LEN)
    else $error("Later adjustment did not lengthen the period by the step.");

  AST_EARLIER: assert property (@(posedge clk_sys) disable iff (rst)
    (adj_go && act == ACT_EARLIER && adj_s >= min_s) |=>
      CNT_W'(len_q + $past(step_ext)) == NOM_LEN)
    else $error("Earlier adjustment did not shorten the period by the step.");

  AST_IGNORE: assert property (@(posedge clk_sys) disable iff (rst)
    (prim_done && act == ACT_NONE && !wrap && !sec_req_q) |=> $stable(len_q) && !sec_req_q)
    else $error("Undecoded combination caused an action.");

  AST_SEC_REQ: assert property (@(posedge clk_sys) disable iff (rst)
    (prim_done && ctl_code == CODE_SEC && term_code == CODE_NONE) |=> sec_req_q)
    else $error("Control bits 11 did not request a secondary frame.");

  AST_SEC_TERM: assert property (@(posedge clk_sys) disable iff (rst)
    (prim_done && ctl_code == CODE_NONE && term_code == CODE_SEC) |=> sec_req_q)
    else $error("Terminals 11 did not request a secondary frame.");

  AST_SEC_HALF: assert property (@(posedge clk_sys) disable iff (rst)
    seq_half_arm |=> sec_arm_q && smp_cnt_q == CNT_W'(HALF_LEN + 1'b1))
    else $error("Secondary frame not armed at half the sample period.");

  AST_ONE_PERIOD: assert property (@(posedge clk_sys) disable iff (rst)
    (wrap && !adj_go) |=> len_q == NOM_LEN && smp_cnt_q == '0 && prim_arm_q)
    else $error("Adjusted period did not return to nominal.");

  AST_ONE_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
    prim_done |=> !prim_done [*2])
    else $error("More than one decode in a primary frame.");

  AST_MIXED_IGNORED: assert property (@(posedge clk_sys) disable iff (rst)
    (prim_done && ctl_code != CODE_NONE && term_code != CODE_NONE && !wrap) |=> $stable(len_q))
    else $error("Mixed control and terminal codes changed the period.");

  AST_SEC_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
    start_sec |=> !frame_sync_n && !dout_oe)
    else $error("Secondary frame did not drop frame sync with the output released.");

  AST_OE_PRIMARY: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(dout_oe) |-> $past(start_prim))
    else $error("Output enable rose outside a primary frame start.");
endmodule : codec_word_ctrl
`default_nettype wire

// >>> shared/codec_word_pkg.sv
// Shared constants and types for the primary serial word controller.
package codec_word_pkg;
  localparam int CLK_PERIOD_NS    = 8;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int SAMPLE_CLKS_DFLT = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int CNT_W            = 24;
  localparam int WORD_W           = 16;
  localparam int DAC_W            = 14;
  localparam int STEP_W           = 8;
  localparam int BIT_W            = 4;
  localparam int SYNC_N           = 4;
  localparam int FIFO_DEPTH       = 16;
  localparam logic [BIT_W-1:0] LAST_BIT = 4'hF;
  localparam logic [CNT_W-1:0] LEN_MIN  = 24'h000040;
  // Pin indices inside the synchroniser vector.
  localparam int PIN_SCLK = 0;
  localparam int PIN_DIN  = 1;
  localparam int PIN_FLO  = 2;
  localparam int PIN_FHI  = 3;
  // One code table serves both the control bits and the function terminals.
  localparam logic [1:0] CODE_NONE    = 2'h0;
  localparam logic [1:0] CODE_LATER   = 2'h1;
  localparam logic [1:0] CODE_EARLIER = 2'h2;
  localparam logic [1:0] CODE_SEC     = 2'h3;
  typedef enum logic [1:0] {ACT_NONE, ACT_LATER, ACT_EARLIER, ACT_SEC} action_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} frame_st_t;
endpackage : codec_word_pkg

// >>> src/word_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module word_fifo #(
  parameter int W     = 14,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  wire logic     push = in_valid && in_ready;
  wire logic     pop  = out_valid && out_ready;

  assign in_ready  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem[rd_q];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q  <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q  <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule : word_fifo
`default_nettype wire

// >>> tb/host_port_model.sv
// Behavioural host serial port: runs the shift clock and exchanges one word per frame.
`timescale 1ns/10ps
`default_nettype none
module host_port_model (
  output logic             sclk,
  output logic             din,
  input  wire logic        frame_sync_n,
  input  wire logic        dout,
  input  wire logic [15:0] tx_word,
  output logic      [15:0] rx_word,
  output logic      [15:0] frames
);
  logic [15:0] sh;
  logic [15:0] rx;
  // Frames begin on a shift-clock rise, so this host keeps the clock running between them.
  initial
  begin
    sclk = 1'b0;
    din = 1'b0;
    rx_word = 16'h0000;
    frames = 16'h0000;
  end
  always #80 sclk = ~sclk;
  always @(negedge frame_sync_n)
  begin
    sh = tx_word;
    din = sh[15];
    for (int i = 0; i < 16; i++)
    begin
      @(negedge sclk);
      rx = {rx[14:0], dout};
      if (i < 15)
      begin
        @(posedge sclk);
        din = sh[14 - i];
      end
    end
    @(posedge sclk);
    // The released line shows the inverse, so a stale bit never passes for data.
    din = ~din;
    rx_word = rx;
    frames = frames + 16'h0001;
  end
endmodule : host_port_model
`default_nettype wire

// >>> tb/codec_word_ctrl_bench.sv
// Self-checking bench for the primary serial word controller.
`timescale 1ns/10ps
`default_nettype none
module codec_word_ctrl_bench;
  import codec_word_pkg::*;
  localparam int SCLKS = 1000;
  localparam int STEP  = 40;
  // Shift clock period of the host model in master-clock periods.
  localparam int SCLK_CLKS = 20;
  localparam logic [1:0] CTL_T [6] = '{2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2};
  localparam logic [1:0] TERM_T [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h1, 2'h2};
  localparam int DLT [6] = '{1, -1, 1, -1, 0, 0};
  logic clk_sys = 1'b0;
  logic rst, sclk, din, fhi, flo, fsn, dout, dout_oe, dac_valid, dac_ready, dac_overrun;
  logic sec_valid, fsn_q, ovr_seen;
  logic signed [STEP_W-1:0] phase_step;
  logic [WORD_W-1:0] adc_word, sec_word, tx_word, rx_word, frames;
  logic [DAC_W-1:0] dac_word;
  logic [1:0] ctl_bits;
  logic [DAC_W-1:0] exp_q[$];
  int num_errors, checked, cyc, last_fall, gap, seq, sec_cnt, ps, oe_run, oe_len;

  always #4 clk_sys = ~clk_sys;

  codec_word_ctrl #(.SAMPLE_CLKS(SCLKS), .DEPTH(FIFO_DEPTH)) dut (
    .clk_sys(clk_sys), .rst(rst), .sclk(sclk), .din(din), .func_term_hi(fhi),
    .func_term_lo(flo), .frame_sync_n(fsn), .dout(dout), .dout_oe(dout_oe),
    .phase_step(phase_step), .adc_word(adc_word), .dac_valid(dac_valid),
    .dac_ready(dac_ready), .dac_word(dac_word), .dac_overrun(dac_overrun),
    .sec_word(sec_word), .sec_valid(sec_valid), .ctl_bits(ctl_bits));

  host_port_model host (.sclk(sclk), .din(din), .frame_sync_n(fsn), .dout(dout),
    .tx_word(tx_word), .rx_word(rx_word), .frames(frames));

  // Frame spacing is measured between sync falls in master-clock periods.
  always @(posedge clk_sys)
  begin
    cyc++;
    fsn_q <= fsn;
    if (fsn_q === 1'b1 && fsn === 1'b0)
    begin
      gap = cyc - last_fall;
      last_fall = cyc;
    end
    if (dac_overrun === 1'b1)
      ovr_seen = 1'b1;
    if (sec_valid === 1'b1)
      sec_cnt++;
    if (dout_oe === 1'b1)
      oe_run++;
    else if (oe_run != 0)
    begin
      oe_len = oe_run;
      oe_run = 0;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic wait_frame;
    logic [15:0] f0;
    int n;
    f0 = frames;
    n = 0;
    while (frames === f0 && n < 3000)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 3000)
    begin
      chk("frame completion", 32'h1, 32'h0);
      end_sim();
    end
    // The enable drops a few cycles after the host ends the word; let that settle.
    repeat (6) @(negedge clk_sys);
  endtask : wait_frame

  task automatic prim(input logic [1:0] ctl, input logic [1:0] term, input logic [15:0] adc);
    logic [15:0] w;
    @(negedge clk_sys);
    w = {14'(seq * 16'h0123 + 16'h0011), ctl};
    seq++;
    tx_word = w;
    fhi = term[1];
    flo = term[0];
    adc_word = adc;
    oe_len = 0;
    wait_frame();
    chk("ctl_bits", 32'(ctl), 32'(ctl_bits));
    chk("dout_oe cycles", 32'(WORD_W * SCLK_CLKS), 32'(oe_len));
    chk("host word", 32'(adc), 32'(rx_word));
    if (exp_q.size() < 16)
      exp_q.push_back(w[15:2]);
  endtask : prim

  initial
  begin
    rst = 1'b1;
    fhi = 1'b0;
    flo = 1'b0;
    phase_step = 8'h00;
    adc_word = 16'h0000;
    dac_ready = 1'b0;
    tx_word = 16'h0000;
    fsn_q = 1'b1;
    ovr_seen = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    prim(2'h0, 2'h0, 16'hA5C3);
    prim(2'h0, 2'h0, 16'h5A3C);
    chk("nominal spacing", 32'(SCLKS), 32'(gap));
    $display("test exchange done");
    for (int s = 0; s < 2; s++)
    begin
      ps = (s == 0) ? STEP : -STEP;
      phase_step = 8'(ps);
      for (int i = 0; i < 6; i++)
      begin
        prim(CTL_T[i], TERM_T[i], 16'(16'h1F00 + i));
        chk("spacing back to nominal", 32'(SCLKS), 32'(gap));
        prim(2'h0, 2'h0, 16'h0F0F);
        chk("adjusted spacing", 32'(SCLKS + DLT[i] * ps), 32'(gap));
      end
    end
    $display("test phase steering done");
    for (int j = 0; j < 2; j++)
    begin
      prim(j ? 2'h3 : 2'h0, j ? 2'h0 : 2'h3, 16'h3C3C);
      tx_word = 16'hC35A ^ 16'(j);
      oe_len = 0;
      wait_frame();
      chk("secondary dout_oe", 32'h0, 32'(oe_len));
      chk("secondary offset", 32'(SCLKS / 2), 32'(gap));
      chk("secondary word", 32'(16'hC35A ^ 16'(j)), 32'(sec_word));
      chk("secondary pulses", 32'(j + 1), 32'(sec_cnt));
      prim(2'h0, 2'h0, 16'h8001);
      chk("primary after secondary", 32'(SCLKS / 2), 32'(gap));
    end
    $display("test secondary done");
    chk("overrun seen", 32'h1, 32'(ovr_seen));
    for (int k = 0; k < 16; k++)
    begin
      chk("dac_valid", 32'h1, 32'(dac_valid));
      chk("dac_word", 32'(exp_q[k]), 32'(dac_word));
      @(negedge clk_sys);
      dac_ready = 1'b1;
      @(negedge clk_sys);
      dac_ready = 1'b0;
    end
    chk("fifo empty", 32'h0, 32'(dac_valid));
    $display("test fifo done");
    end_sim();
  end
endmodule : codec_word_ctrl_bench
`default_nettype wire
